// *** hdl/prp_sync.sv ***
// Two-stage synchroniser for the zero-cross and overcurrent pins
`timescale 1ns/1ps
module prp_sync
  import prp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);

  prp_sync_state_type s;
  prp_sync_state_type next_s;

  always_comb
  begin
    next_s = s;
    for (int i = 0; i < 2; i++)
    begin
      next_s.stage1[i] = pin_in[i];
      next_s.stage2[i] = s.stage1[i];
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign pin_sync = s.stage2;

endmodule // prp_sync

// *** hdl/prp_top.sv ***
// Retriggered boost-switch pulse generator with overcurrent stop
//
// Behaviour
// - ON duration stays constant for every cycle until software loads a new one.
// - Zero-cross trigger aborts the OFF phase and starts a new ON phase.
// - Overcurrent forces the dead-time state until software restarts the unit.
// - Generator A times ON, generator B times OFF; only output A drives.
// - Fault mode 7 makes overcurrent stop both generators and both outputs.
// - Start-up pulses run without retrigger until the first zero-cross is seen.
`timescale 1ns/1ps
module prp_top
  import prp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        zero_cross_trigger_pin,
  input  wire logic        overcurrent_trip,
  output logic             gate_a,
  output logic             gate_b,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    prp_phase_type        phase;
    logic                 enable;
    logic                 fault;
    logic                 auto_run;
    logic                 zc_prev;
    logic                 gate;
    logic [3:0]           mode_b;
    logic [3:0]           mode_a;
    logic [PRP_TW-1:0]    on_time;
    logic [PRP_TW-1:0]    on_active;
    logic [PRP_TW-1:0]    off_time;
    logic [PRP_EVT_W-1:0] status;
    logic [PRP_EVT_W-1:0] mask;
    logic [31:0]          rdata;
  } prp_top_state_type;

  prp_top_state_type s;
  prp_top_state_type next_s;
  prp_bus_req_type   req;

  logic [1:0] pin_sync;
  logic       zc_lvl;
  logic       oc_lvl;
  logic       zc_edge;
  logic       retrig_ok;
  logic       stop_all;
  logic       restart_wr;
  logic       a_start;
  logic       a_stop;
  logic       b_start;
  logic       b_stop;
  logic       a_busy;
  logic       a_done;
  logic       b_busy;
  logic       b_done;
  logic [PRP_EVT_W-1:0] evt;

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  function automatic logic hit_wr(input prp_bus_req_type r, input logic [7:0] a);
    hit_wr = r.wr && (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  prp_sync u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pin_in   ({overcurrent_trip, zero_cross_trigger_pin}),
    .pin_sync (pin_sync)
  );

  assign zc_lvl     = pin_sync[0];
  assign oc_lvl     = pin_sync[1];
  assign zc_edge    = zc_lvl && !s.zc_prev;
  assign retrig_ok  = s.auto_run && (s.mode_b == PRP_MODE_RETRIG);
  assign stop_all   = oc_lvl && (s.mode_a == PRP_MODE_FAULT7);
  assign restart_wr = hit_wr(req, PRP_ADDR_CTRL) && req.wdata[PRP_CTRL_RESTART];

  // ----------------------------------------------------------------
  // Sequencing of the two generators
  // ----------------------------------------------------------------
  always_comb
  begin
    a_start = 1'b0;
    b_start = 1'b0;
    a_stop  = oc_lvl || s.fault || !s.enable;
    b_stop  = stop_all || !s.enable || (s.fault && s.mode_a == PRP_MODE_FAULT7);
    if (!a_stop)
    begin
      case (s.phase)
        PRP_IDLE: a_start = 1'b1;
        PRP_ON:   b_start = a_done;
        PRP_OFF:  a_start = (retrig_ok && zc_edge) || b_done;
        default:  a_start = 1'b0;
      endcase
    end
    if (a_start)
      b_stop = 1'b1;
  end

  assign evt = {a_start, zc_edge, oc_lvl};

  // ----------------------------------------------------------------
  // Next state and registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s         = s;
    next_s.zc_prev = zc_lvl;
    next_s.rdata   = '0;

    if (hit_wr(req, PRP_ADDR_CTRL))
      next_s.enable = req.wdata[PRP_CTRL_ENABLE];
    if (hit_wr(req, PRP_ADDR_ON))
      next_s.on_time = req.wdata[PRP_TW-1:0];
    if (hit_wr(req, PRP_ADDR_OFF))
      next_s.off_time = req.wdata[PRP_TW-1:0];
    if (hit_wr(req, PRP_ADDR_MODE))
    begin
      next_s.mode_b = req.wdata[3:0];
      next_s.mode_a = req.wdata[7:4];
    end
    if (hit_wr(req, PRP_ADDR_MASK))
      next_s.mask = req.wdata[PRP_EVT_W-1:0];
    // Set wins over the write-one clear so no event is lost
    if (hit_wr(req, PRP_ADDR_STATUS))
      next_s.status = s.status & ~req.wdata[PRP_EVT_W-1:0];
    next_s.status = next_s.status | evt;

    // Fault stays latched while the comparator is still high
    if (restart_wr)
      next_s.fault = 1'b0;
    if (oc_lvl)
      next_s.fault = 1'b1;

    if (zc_edge && s.phase != PRP_IDLE && s.phase != PRP_DEAD)
      next_s.auto_run = 1'b1;

    if (a_start)
    begin
      next_s.on_active = s.on_time;
      next_s.phase     = PRP_ON;
    end
    else if (b_start)
      next_s.phase = PRP_OFF;

    if (oc_lvl || s.fault)
    begin
      next_s.phase = PRP_DEAD;
      if (restart_wr && !oc_lvl)
      begin
        next_s.phase    = PRP_IDLE;
        next_s.auto_run = 1'b0;
      end
    end
    else if (!s.enable)
    begin
      next_s.phase    = PRP_IDLE;
      next_s.auto_run = 1'b0;
    end
    else if (s.phase == PRP_DEAD)
      next_s.phase = restart_wr ? PRP_IDLE : PRP_DEAD;

    next_s.gate = (next_s.phase == PRP_ON);

    if (req.rd)
    begin
      case (req.addr)
        PRP_ADDR_CTRL:   next_s.rdata = {31'h00000000, s.enable};
        PRP_ADDR_ON:     next_s.rdata = {16'h0000, s.on_time};
        PRP_ADDR_OFF:    next_s.rdata = {16'h0000, s.off_time};
        PRP_ADDR_MODE:   next_s.rdata = {24'h000000, s.mode_a, s.mode_b};
        PRP_ADDR_STATUS: next_s.rdata = {29'h00000000, s.status};
        PRP_ADDR_MASK:   next_s.rdata = {29'h00000000, s.mask};
        PRP_ADDR_STATE:  next_s.rdata = {s.on_active, 10'h000, a_busy, b_busy,
                                         s.auto_run, s.fault, s.phase};
        default:         next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      s           <= '0;
      s.phase     <= PRP_IDLE;
      s.mode_b    <= PRP_MODE_RETRIG;
      s.mode_a    <= PRP_MODE_FAULT7;
      s.on_time   <= PRP_ON_RST;
      s.on_active <= PRP_ON_RST;
      s.off_time  <= PRP_OFF_RST;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // Generators
  // ----------------------------------------------------------------
  prp_wavegen u_gen_a (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (a_start),
    .stop     (a_stop),
    .duration (s.on_time),
    .busy     (a_busy),
    .done     (a_done)
  );

  // Without a zero-cross, the OFF limit still restarts the cycle
  prp_wavegen u_gen_b (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .start    (b_start),
    .stop     (b_stop),
    .duration (s.off_time),
    .busy     (b_busy),
    .done     (b_done)
  );

  assign gate_a    = s.gate;
  assign gate_b    = 1'b0;
  assign bus_rdata = s.rdata;
  assign irq       = |(s.status & s.mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_trip_dead;
    @(posedge clk_sys) disable iff (reset)
    oc_lvl |=> (s.phase == PRP_DEAD) && !gate_a;
  endproperty
  a_trip_dead: assert property (p_trip_dead) else $error("trip did not force dead");

  property p_dead_holds;
    @(posedge clk_sys) disable iff (reset)
    (s.phase == PRP_DEAD) && !restart_wr |=> (s.phase == PRP_DEAD);
  endproperty
  a_dead_holds: assert property (p_dead_holds) else $error("dead left without restart");

  property p_retrig;
    @(posedge clk_sys) disable iff (reset)
    (s.phase == PRP_OFF) && retrig_ok && zc_edge && !oc_lvl && !s.fault && s.enable
      |=> (s.phase == PRP_ON) && gate_a && !b_busy;
  endproperty
  a_retrig: assert property (p_retrig) else $error("zero-cross did not retrigger");

  property p_on_const;
    @(posedge clk_sys) disable iff (reset)
    (s.phase == PRP_ON) && $past(s.phase == PRP_ON) |-> $stable(s.on_active);
  endproperty
  a_on_const: assert property (p_on_const) else $error("on duration changed");

  property p_load_next;
    @(posedge clk_sys) disable iff (reset)
    a_start |=> (s.on_active == $past(s.on_time)) && a_busy;
  endproperty
  a_load_next: assert property (p_load_next) else $error("on duration not latched");

  property p_stop_both;
    @(posedge clk_sys) disable iff (reset)
    stop_all |=> !a_busy && !b_busy && !gate_a ##1 !a_busy && !b_busy;
  endproperty
  a_stop_both: assert property (p_stop_both) else $error("fault did not stop both");

  property p_startup;
    @(posedge clk_sys) disable iff (reset)
    !s.auto_run && (s.phase == PRP_OFF) && zc_edge && !b_done && !oc_lvl && !s.fault
      && s.enable |=> s.auto_run && (s.phase == PRP_OFF);
  endproperty
  a_startup: assert property (p_startup) else $error("start-up retriggered");

  property p_no_mode;
    @(posedge clk_sys) disable iff (reset)
    (s.mode_b != PRP_MODE_RETRIG) && (s.phase == PRP_OFF) && zc_edge && !b_done
      && !oc_lvl && !s.fault && s.enable |=> (s.phase == PRP_OFF);
  endproperty
  a_no_mode: assert property (p_no_mode) else $error("retrigger without mode");

  property p_gate_b;
    @(posedge clk_sys) disable iff (reset)
    a_done && (s.phase == PRP_ON) && !a_stop |=> !gate_a && b_busy && !gate_b;
  endproperty
  a_gate_b: assert property (p_gate_b) else $error("off phase not on generator b");

  c_trip:    cover property (@(posedge clk_sys) disable iff (reset)
                            $fell(oc_lvl) ##[1:100] restart_wr);
  c_soft:    cover property (@(posedge clk_sys) disable iff (reset)
                            oc_lvl && (s.mode_a != PRP_MODE_FAULT7) && b_busy);
  c_retrig:  cover property (@(posedge clk_sys) disable iff (reset)
                            (s.phase == PRP_OFF) && retrig_ok && zc_edge);
  c_startup: cover property (@(posedge clk_sys) disable iff (reset) $rose(s.auto_run));

endmodule // prp_top

// *** hdl/prp_wavegen.sv ***
// One waveform generator: times a single phase and pulses when it ends
`timescale 1ns/1ps
module prp_wavegen
  import prp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              start,
  input  wire logic              stop,
  input  wire logic [PRP_TW-1:0] duration,
  output logic                   busy,
  output logic                   done
);

  prp_gen_state_type s;
  prp_gen_state_type next_s;

  always_comb
  begin
    next_s      = s;
    next_s.done = 1'b0;
    if (stop)
    begin
      next_s.busy = 1'b0;
    end
    else if (start)
    begin
      // A zero duration still gives one cycle so a phase is never skipped
      next_s.busy = 1'b1;
      next_s.cnt  = (duration == '0) ? 16'h0001 : duration;
    end
    else if (s.busy)
    begin
      if (s.cnt == 16'h0001)
      begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
      else
        next_s.cnt = s.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      s <= '0;
    else
      s <= next_s;
  end

  assign busy = s.busy;
  assign done = s.done;

endmodule // prp_wavegen

// *** shared/prp_pkg.sv ***
// Shared constants and types for the retriggered PFC pulse generator
package prp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  PRP_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  PRP_ADDR_ON     = 8'h04;
  localparam logic [7:0]  PRP_ADDR_OFF    = 8'h08;
  localparam logic [7:0]  PRP_ADDR_MODE   = 8'h0C;
  localparam logic [7:0]  PRP_ADDR_STATUS = 8'h10;
  localparam logic [7:0]  PRP_ADDR_MASK   = 8'h14;
  localparam logic [7:0]  PRP_ADDR_STATE  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PRP_CTRL_ENABLE  = 0;
  localparam int unsigned PRP_CTRL_RESTART = 1;
  localparam int unsigned PRP_ST_TRIP      = 0;
  localparam int unsigned PRP_ST_ZC        = 1;
  localparam int unsigned PRP_ST_CYCLE     = 2;
  localparam int unsigned PRP_EVT_W        = 3;
  localparam int unsigned PRP_TW           = 16;

  // ----------------------------------------------------------------
  // Mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  PRP_MODE_RETRIG  = 4'h8;
  localparam logic [3:0]  PRP_MODE_FAULT7  = 4'h7;
  localparam logic [15:0] PRP_ON_RST       = 16'h0010;
  localparam logic [15:0] PRP_OFF_RST      = 16'h0040;

  typedef enum logic [1:0] {
    PRP_IDLE = 2'b00,
    PRP_ON   = 2'b01,
    PRP_OFF  = 2'b10,
    PRP_DEAD = 2'b11
  } prp_phase_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } prp_bus_req_type;

  typedef struct packed {
    logic                    busy;
    logic                    done;
    logic [PRP_TW-1:0]       cnt;
  } prp_gen_state_type;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } prp_sync_state_type;

endpackage

// *** verif/prp_partner.sv ***
// Far-side model: inductor zero-cross winding and shunt current comparator
`timescale 1ns/1ps
module prp_partner
(
  input  wire logic clk_sys,
  input  wire logic gate_a,
  input  wire logic zc_en,
  input  wire logic trip_cmd,
  output logic      zero_cross_trigger_pin,
  output logic      overcurrent_trip
);
  // Cycles the inductor needs to run dry after the switch opens
  localparam int DEMAG = 10;

  int   cnt    = 0;
  logic gate_q = 1'b0;

  // Pins settle on the first clock edge, well inside the reset hold
  always @(posedge clk_sys)
  begin
    gate_q <= gate_a;
    if (gate_q && !gate_a)
      cnt <= DEMAG + 3;
    else if (cnt > 0)
      cnt <= cnt - 1;
    // Winding rings high for three cycles once the current reaches zero
    zero_cross_trigger_pin <= zc_en && cnt > 0 && cnt <= 3;
    overcurrent_trip <= trip_cmd;
  end
endmodule  // prp_partner

// *** verif/prp_top_tb_top.sv ***
// Self-checking bench for the retriggered pulse generator
`timescale 1ns/1ps
module prp_top_tb_top
  import prp_pkg::*;
;
  logic        clk_sys;
  logic        reset;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic        bus_wr;
  logic        bus_rd;
  logic        zero_cross_trigger_pin;
  logic        overcurrent_trip;
  logic        gate_a;
  logic        gate_b;
  logic        irq;
  logic        zc_en;
  logic        trip_cmd;
  int          failures;
  int          checks;

  prp_top u_dut (
    .clk_sys(clk_sys), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .zero_cross_trigger_pin(zero_cross_trigger_pin), .overcurrent_trip(overcurrent_trip),
    .gate_a(gate_a), .gate_b(gate_b), .irq(irq));

  prp_partner u_far (
    .clk_sys(clk_sys), .gate_a(gate_a), .zc_en(zc_en), .trip_cmd(trip_cmd),
    .zero_cross_trigger_pin(zero_cross_trigger_pin), .overcurrent_trip(overcurrent_trip));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  task automatic expect_reg(input string what, input logic [7:0] a,
                            input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(negedge clk_sys);
    check(what, bus_rdata & m, exp);
  endtask

  // Bounded wait so a stuck gate cannot hang the run
  task automatic wait_level(input logic lvl);
    int n;
    n = 0;
    while (gate_a !== lvl && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
    end
    check("gate_a level", {31'h0, gate_a}, {31'h0, lvl});
  endtask

  task automatic run_len(input logic lvl, output int w);
    w = 0;
    while (gate_a === lvl && w < 2000)
    begin
      w++;
      @(negedge clk_sys);
    end
  endtask

  task automatic pulse(output int on_w, output int off_w);
    @(negedge clk_sys);
    wait_level(1'b0);
    wait_level(1'b1);
    run_len(1'b1, on_w);
    run_len(1'b0, off_w);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    expect_reg("mode", PRP_ADDR_MODE, 32'h0000_00FF, 32'h0000_0078);
    expect_reg("on", PRP_ADDR_ON, 32'h0000_FFFF, {16'h0000, PRP_ON_RST});
    expect_reg("off", PRP_ADDR_OFF, 32'h0000_FFFF, {16'h0000, PRP_OFF_RST});
    expect_reg("status", PRP_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    bus_write(8'h1C, 32'hFFFF_FFFF);
    expect_reg("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    check("gate_a idle", {31'h0, gate_a}, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_on_time();
    int a1, f1, a2, f2, w;
    bus_write(PRP_ADDR_CTRL, 32'h0000_0001);
    pulse(a1, f1);
    pulse(a2, f2);
    check("on width repeat", a2, a1);
    @(negedge clk_sys);
    wait_level(1'b0);
    wait_level(1'b1);
    bus_write(PRP_ADDR_ON, 32'h0000_0018);
    @(negedge clk_sys);
    run_len(1'b1, w);
    check("on width during load", 2 + w, a1);
    pulse(a2, f2);
    check("on width after load", a2, a1 + 8);
    bus_write(PRP_ADDR_ON, {16'h0000, PRP_ON_RST});
    check("gate_b unused", {31'h0, gate_b}, 32'h0000_0000);
    $display("test on time done");
  endtask

  task automatic t_startup();
    int a, f;
    expect_reg("auto before", PRP_ADDR_STATE, 32'h0000_0008, 32'h0000_0000);
    @(negedge clk_sys);
    wait_level(1'b1);
    @(posedge clk_sys);
    zc_en <= 1'b1;
    @(negedge clk_sys);
    run_len(1'b1, a);
    run_len(1'b0, f);
    check("first off long", {31'h0, f > 40}, 32'h0000_0001);
    pulse(a, f);
    check("off retriggered", {31'h0, f <= 30}, 32'h0000_0001);
    expect_reg("auto after", PRP_ADDR_STATE, 32'h0000_0008, 32'h0000_0008);
    expect_reg("events", PRP_ADDR_STATUS, 32'h0000_0006, 32'h0000_0006);
    $display("test startup done");
  endtask

  task automatic t_mode();
    int a, f;
    bus_write(PRP_ADDR_MODE, 32'h0000_0070);
    pulse(a, f);
    pulse(a, f);
    check("no retrigger", {31'h0, f > 40}, 32'h0000_0001);
    bus_write(PRP_ADDR_MODE, {24'h0, PRP_MODE_FAULT7, PRP_MODE_RETRIG});
    pulse(a, f);
    pulse(a, f);
    check("retrigger back", {31'h0, f <= 30}, 32'h0000_0001);
    $display("test mode done");
  endtask

  task automatic t_trip();
    bus_write(PRP_ADDR_MASK, 32'h0000_0001);
    @(negedge clk_sys);
    wait_level(1'b1);
    @(posedge clk_sys);
    trip_cmd <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check("gate cut", {31'h0, gate_a}, 32'h0000_0000);
    repeat (40) @(negedge clk_sys);
    check("gate held", {31'h0, gate_a}, 32'h0000_0000);
    check("gate_b held", {31'h0, gate_b}, 32'h0000_0000);
    check("irq trip", {31'h0, irq}, 32'h0000_0001);
    expect_reg("dead both", PRP_ADDR_STATE, 32'h0000_0033, 32'h0000_0003);
    @(posedge clk_sys);
    trip_cmd <= 1'b0;
    repeat (20) @(negedge clk_sys);
    check("dead until restart", {31'h0, gate_a}, 32'h0000_0000);
    bus_write(PRP_ADDR_STATUS, 32'h0000_0001);
    repeat (3) @(negedge clk_sys);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    bus_write(PRP_ADDR_CTRL, 32'h0000_0003);
    expect_reg("auto reset", PRP_ADDR_STATE, 32'h0000_0008, 32'h0000_0000);
    wait_level(1'b1);
    bus_write(PRP_ADDR_MASK, 32'h0000_0000);
    $display("test trip done");
  endtask

  // Trip in the OFF phase with a fault mode other than 7: generator B runs on
  task automatic t_trip_soft();
    bus_write(PRP_ADDR_MODE, {24'h0, 4'h0, PRP_MODE_RETRIG});
    @(negedge clk_sys);
    wait_level(1'b1);
    wait_level(1'b0);
    @(posedge clk_sys);
    trip_cmd <= 1'b1;
    repeat (6) @(negedge clk_sys);
    expect_reg("dead gen b runs", PRP_ADDR_STATE, 32'h0000_0033, 32'h0000_0013);
    @(posedge clk_sys);
    trip_cmd <= 1'b0;
    repeat (20) @(negedge clk_sys);
    check("soft trip gate", {31'h0, gate_a}, 32'h0000_0000);
    bus_write(PRP_ADDR_CTRL, 32'h0000_0003);
    bus_write(PRP_ADDR_MODE, {24'h0, PRP_MODE_FAULT7, PRP_MODE_RETRIG});
    @(negedge clk_sys);
    wait_level(1'b1);
    bus_write(PRP_ADDR_CTRL, 32'h0000_0000);
    repeat (3) @(negedge clk_sys);
    expect_reg("disabled idle", PRP_ADDR_STATE, 32'h0000_0003, 32'h0000_0000);
    check("gate off disabled", {31'h0, gate_a}, 32'h0000_0000);
    $display("test soft trip done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    reset     = 1'b1;
    bus_addr  = 8'h00;
    bus_wdata = 32'h0000_0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    zc_en     = 1'b0;
    trip_cmd  = 1'b0;
    failures  = 0;
    checks    = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_on_time();
    t_startup();
    t_mode();
    t_trip();
    t_trip_soft();
    close_out();
  end

  // Scenarios need under two thousand cycles; the 20000-cycle limit allows ample margin
  initial
  begin
    #1000000;
    failures++;
    $display("BAD watchdog expected done seen hang");
    close_out();
  end
endmodule  // prp_top_tb_top
